/* File: verilog/exec_pkg.sv */
// Package: constants, types and helpers for the file-register ALU and bit-op executor
// Overview of operation
// - Opcode 00 0111 adds the accumulator to the addressed file register and updates C, DC and Z.
// - For byte file operations the result goes to the accumulator when d is 0, to the file register when d is 1.
// - Opcode 00 0101 ANDs the accumulator with the file register, routes it by d, and updates only Z.
// - Opcodes 01 00bb and 01 01bb clear or set bit b of the file register and leave the flags alone.
// - A bit test that finds the bit clear discards the prefetched word and runs a no-op cycle instead.
// - Opcode 01 10bb is the bit test skip if clear; fetch overlaps execution and no flag changes.
// - A read of an I/O port register takes the synchronised pin levels, not the output latch.
// - A byte or bit write to the timer-zero counter clears the prescaler when it is assigned there.
package exec_pkg;

   // ****************************************
   // Widths
   // ****************************************
   localparam int DATA_W = 8;
   localparam int INSTR_W = 14;
   localparam int FADDR_W = 7;
   localparam int REG_AW = 3;

   // ****************************************
   // Instruction fields
   // ****************************************
   localparam int CLASS_MSB = 13;
   localparam int CLASS_LSB = 12;
   localparam int OPC_MSB = 11;
   localparam int OPC_LSB = 8;
   localparam int DEST_POS = 7;
   localparam int BIDX_MSB = 9;
   localparam int BIDX_LSB = 7;
   localparam logic [1:0] CLASS_BYTE = 2'h0;
   localparam logic [1:0] CLASS_BIT = 2'h1;
   localparam logic [3:0] OPC_ADD = 4'h7;
   localparam logic [3:0] OPC_AND = 4'h5;
   localparam logic [1:0] BOP_CLR = 2'h0;
   localparam logic [1:0] BOP_SET = 2'h1;
   localparam logic [1:0] BOP_TSC = 2'h2;

   // ****************************************
   // File space addresses
   // ****************************************
   localparam logic [6:0] TMR0_ADDR = 7'h01;
   localparam logic [6:0] PORTA_ADDR = 7'h05;
   localparam logic [6:0] PORTB_ADDR = 7'h06;

   // ****************************************
   // Flag positions and software registers
   // ****************************************
   localparam int FLAG_C = 0;
   localparam int FLAG_DC = 1;
   localparam int FLAG_Z = 2;
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_ACC = 3'h1;
   localparam logic [2:0] REG_FLAGS = 3'h2;
   localparam logic [2:0] REG_COUNT = 3'h3;
   localparam logic [2:0] REG_SKIPS = 3'h4;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_PSA = 1;
   localparam logic [7:0] CTRL_RST = 8'h01;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [2:0] FLAGS_RST = 3'h0;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_ADD = 3'h1,
      OP_AND = 3'h2,
      OP_BCLR = 3'h3,
      OP_BSET = 3'h4,
      OP_BTSC = 3'h5
   } op_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_FLUSH = 2'b11
   } state_e;

   typedef struct packed {
      op_e op;
      logic dest;
      logic [2:0] bidx;
      logic [6:0] faddr;
   } dec_s;

   typedef struct packed {
      logic [7:0] res;
      logic c;
      logic dc;
      logic z;
      logic bit_val;
   } alu_s;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic dec_s decode(input logic [13:0] w);
      dec_s d;
      d.op = OP_NONE;
      d.dest = w[DEST_POS];
      d.bidx = w[BIDX_MSB:BIDX_LSB];
      d.faddr = w[6:0];
      if (w[CLASS_MSB:CLASS_LSB] == CLASS_BYTE) begin
         if (w[OPC_MSB:OPC_LSB] == OPC_ADD)
            d.op = OP_ADD;
         else if (w[OPC_MSB:OPC_LSB] == OPC_AND)
            d.op = OP_AND;
      end else if (w[CLASS_MSB:CLASS_LSB] == CLASS_BIT) begin
         if (w[11:10] == BOP_CLR)
            d.op = OP_BCLR;
         else if (w[11:10] == BOP_SET)
            d.op = OP_BSET;
         else if (w[11:10] == BOP_TSC)
            d.op = OP_BTSC;
      end
      return d;
   endfunction

   function automatic logic [7:0] bit_mask(input logic [2:0] b);
      return 8'(8'h01 << b);
   endfunction

endpackage

/* File: verilog/file_alu.sv */
// Combinational ALU for add, AND and single-bit operations on a file operand
`timescale 1ns/1ps
`default_nettype none
module file_alu
   import exec_pkg::*;
(
   // Operation
   input wire op_e op,
   input wire logic [2:0] bidx,
   // Operands
   input wire logic [7:0] acc,
   input wire logic [7:0] opnd,
   // Result
   output var alu_s out
);

   wire logic [8:0] sum;
   wire logic [4:0] low_sum;
   wire logic [7:0] mask;
   wire logic [7:0] res;

   assign sum = {1'b0, acc} + {1'b0, opnd};
   assign low_sum = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
   assign mask = bit_mask(bidx);

   // Bit test never writes, so its result is the plain operand
   assign res = (op == OP_ADD) ? sum[7:0] :
                (op == OP_AND) ? (acc & opnd) :
                (op == OP_BCLR) ? (opnd & ~mask) :
                (op == OP_BSET) ? (opnd | mask) :
                opnd;

   assign out.res = res;
   assign out.c = sum[8];
   assign out.dc = low_sum[4];
   assign out.z = (res == 8'h00);
   assign out.bit_val = |(opnd & mask);

endmodule
`default_nettype wire

/* File: verilog/file_reg_alu_bit_ops.sv */
// Executor for add, AND, bit clear, bit set and bit-test-skip-if-clear on file registers
`timescale 1ns/1ps
`default_nettype none
module file_reg_alu_bit_ops
   import exec_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic ARST_N,
   // Program fetch
   input wire logic [13:0] FETCH_WORD,
   input wire logic FETCH_VALID,
   output logic RETIRE,
   output logic SKIP_FLUSH,
   // File register space
   output logic [6:0] FILE_ADDR,
   input wire logic [7:0] FILE_RDATA,
   output logic FILE_WE,
   output logic [6:0] FILE_WADDR,
   output logic [7:0] FILE_WDATA,
   // Port pins
   input wire logic [7:0] PORTA_PINS,
   input wire logic [7:0] PORTB_PINS,
   // Timer zero
   output logic PRESCALER_CLR,
   // Accumulator and flags
   output logic [7:0] ACC,
   output logic [2:0] FLAGS,
   // Register port
   input wire logic [2:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA
);

   // ****************************************
   // State
   // ****************************************
   state_e state_q, state_d;
   logic [13:0] ir_q;
   logic ir_vld_q;
   logic [7:0] acc_q, acc_d;
   logic [2:0] flags_q, flags_d;
   logic [7:0] ctrl_q;
   logic [7:0] count_q;
   logic [7:0] skips_q;
   logic [6:0] faddr_q;
   logic we_q;
   logic [6:0] waddr_q;
   logic [7:0] wdata_q;
   logic retire_q;
   logic flush_q;
   logic psc_q;
   logic [7:0] rdata_q;
   logic [7:0] pa1_q, pa2_q, pb1_q, pb2_q;

   // ****************************************
   // Decode
   // ****************************************
   dec_s dec;
   alu_s alu;
   wire logic run;
   wire logic exec;
   wire logic op_byte;
   wire logic is_port;
   wire logic [7:0] port_val;
   wire logic fwd_hit;
   wire logic [7:0] opnd;
   wire logic skip_taken;
   wire logic file_wr;
   wire logic acc_wr;
   wire logic sw_ctrl_wr;
   wire logic sw_acc_wr;
   wire logic sw_flag_wr;
   wire logic [7:0] rd_mux;

   assign dec = decode(ir_q);
   assign run = ctrl_q[CTRL_RUN];
   // The flush state is what throws away the prefetched word
   assign exec = (state_q == ST_EXEC) && ir_vld_q;
   assign op_byte = (dec.op == OP_ADD) || (dec.op == OP_AND);
   assign is_port = (dec.faddr == PORTA_ADDR) || (dec.faddr == PORTB_ADDR);
   assign port_val = (dec.faddr == PORTA_ADDR) ? pa2_q : pb2_q;
   // Back-to-back use of a just written register must see the new value
   assign fwd_hit = we_q && (waddr_q == faddr_q);
   assign opnd = is_port ? port_val :
                 fwd_hit ? wdata_q : FILE_RDATA;
   assign skip_taken = exec && (dec.op == OP_BTSC) && !alu.bit_val;
   assign file_wr = exec && ((op_byte && dec.dest) ||
                    (dec.op == OP_BCLR) || (dec.op == OP_BSET));
   assign acc_wr = exec && op_byte && !dec.dest;

   assign sw_ctrl_wr = REG_WR && (REG_ADDR == REG_CTRL);
   assign sw_acc_wr = REG_WR && (REG_ADDR == REG_ACC);
   assign sw_flag_wr = REG_WR && (REG_ADDR == REG_FLAGS);

   file_alu i_file_alu (
      .op(dec.op),
      .bidx(dec.bidx),
      .acc(acc_q),
      .opnd(opnd),
      .out(alu)
   );

   // ****************************************
   // Next values
   // ****************************************
   // Software writes take the cycle over any executing update
   assign acc_d = sw_acc_wr ? REG_WDATA :
                  acc_wr ? alu.res : acc_q;
   assign flags_d[FLAG_C] = sw_flag_wr ? REG_WDATA[FLAG_C] :
                            (exec && dec.op == OP_ADD) ? alu.c :
                            flags_q[FLAG_C];
   assign flags_d[FLAG_DC] = sw_flag_wr ? REG_WDATA[FLAG_DC] :
                             (exec && dec.op == OP_ADD) ? alu.dc :
                             flags_q[FLAG_DC];
   assign flags_d[FLAG_Z] = sw_flag_wr ? REG_WDATA[FLAG_Z] :
                            (exec && op_byte) ? alu.z :
                            flags_q[FLAG_Z];

   assign rd_mux = (REG_ADDR == REG_CTRL) ? ctrl_q :
                   (REG_ADDR == REG_ACC) ? acc_q :
                   (REG_ADDR == REG_FLAGS) ? {5'h00, flags_q} :
                   (REG_ADDR == REG_COUNT) ? count_q :
                   (REG_ADDR == REG_SKIPS) ? skips_q : 8'h00;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: state_d = ST_EXEC;
         ST_EXEC: state_d = skip_taken ? ST_FLUSH : ST_EXEC;
         ST_FLUSH: state_d = ST_EXEC;
         default: state_d = ST_IDLE;
      endcase
      if (!run) begin
         state_d = ST_IDLE;
      end
   end

   // ****************************************
   // Pin synchronisers
   // ****************************************
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pa1_q <= 8'h00;
         pa2_q <= 8'h00;
         pb1_q <= 8'h00;
         pb2_q <= 8'h00;
      end else begin
         pa1_q <= PORTA_PINS;
         pa2_q <= pa1_q;
         pb1_q <= PORTB_PINS;
         pb2_q <= pb1_q;
      end
   end

   // ****************************************
   // Fetch and sequencing
   // ****************************************
   // Prefetch overlaps execution; the file address is registered with the word
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_q <= ST_IDLE;
         ir_q <= 14'h0000;
         ir_vld_q <= 1'b0;
         faddr_q <= 7'h00;
      end else begin
         state_q <= state_d;
         ir_q <= FETCH_WORD;
         ir_vld_q <= FETCH_VALID && run;
         faddr_q <= FETCH_WORD[6:0];
      end
   end

   // ****************************************
   // Execution results
   // ****************************************
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         acc_q <= ACC_RST;
         flags_q <= FLAGS_RST;
         we_q <= 1'b0;
         waddr_q <= 7'h00;
         wdata_q <= 8'h00;
         retire_q <= 1'b0;
         flush_q <= 1'b0;
         psc_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         flags_q <= flags_d;
         we_q <= file_wr;
         waddr_q <= dec.faddr;
         wdata_q <= alu.res;
         retire_q <= exec;
         flush_q <= skip_taken;
         psc_q <= file_wr && (dec.faddr == TMR0_ADDR) && ctrl_q[CTRL_PSA];
      end
   end

   // ****************************************
   // Register port
   // ****************************************
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ctrl_q <= CTRL_RST;
         count_q <= 8'h00;
         skips_q <= 8'h00;
         rdata_q <= 8'h00;
      end else begin
         if (sw_ctrl_wr) begin
            ctrl_q <= REG_WDATA;
         end
         count_q <= count_q + {7'h00, exec};
         skips_q <= skips_q + {7'h00, skip_taken};
         rdata_q <= REG_RD ? rd_mux : 8'h00;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign RETIRE = retire_q;
   assign SKIP_FLUSH = flush_q;
   assign FILE_ADDR = faddr_q;
   assign FILE_WE = we_q;
   assign FILE_WADDR = waddr_q;
   assign FILE_WDATA = wdata_q;
   assign PRESCALER_CLR = psc_q;
   assign ACC = acc_q;
   assign FLAGS = flags_q;
   assign REG_RDATA = rdata_q;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);

   sequence s_skip;
      skip_taken && run && !sw_ctrl_wr;
   endsequence

   sequence s_flush_then_resume;
      SKIP_FLUSH && (state_q == ST_FLUSH) ##1 !RETIRE;
   endsequence

   property p_add_flags;
      exec && dec.op == OP_ADD && !sw_flag_wr |=>
         FLAGS[FLAG_Z] == ($past(alu.res) == 8'h00) &&
         FLAGS[FLAG_C] == $past(alu.c) && FLAGS[FLAG_DC] == $past(alu.dc);
   endproperty
   a_add_flags: assert property (p_add_flags)
      else $error("add did not update flags");

   property p_dest_acc;
      acc_wr && !sw_acc_wr |=> ACC == $past(alu.res) && !FILE_WE;
   endproperty
   a_dest_acc: assert property (p_dest_acc)
      else $error("result with d=0 not in accumulator");

   property p_dest_file;
      exec && op_byte && dec.dest && !sw_acc_wr |=>
         FILE_WE && FILE_WADDR == $past(dec.faddr) && $stable(ACC);
   endproperty
   a_dest_file: assert property (p_dest_file)
      else $error("result with d=1 not written to file");

   property p_and_flags;
      exec && dec.op == OP_AND && !sw_flag_wr |=>
         $stable(FLAGS[FLAG_C]) && $stable(FLAGS[FLAG_DC]) &&
         FLAGS[FLAG_Z] == ($past(acc_q & opnd) == 8'h00);
   endproperty
   a_and_flags: assert property (p_and_flags)
      else $error("and touched wrong flags");

   property p_bit_write;
      exec && (dec.op == OP_BCLR || dec.op == OP_BSET) && !sw_flag_wr |=>
         FILE_WE && $stable(FLAGS) &&
         ((FILE_WDATA & bit_mask($past(dec.bidx))) != 8'h00) == ($past(dec.op) == OP_BSET);
   endproperty
   a_bit_write: assert property (p_bit_write)
      else $error("bit clear or set wrote wrong value");

   property p_skip;
      s_skip |=> s_flush_then_resume;
   endproperty
   a_skip: assert property (p_skip)
      else $error("taken skip did not flush one word");

   property p_btsc_quiet;
      exec && dec.op == OP_BTSC && !sw_flag_wr |=> $stable(FLAGS) && !FILE_WE;
   endproperty
   a_btsc_quiet: assert property (p_btsc_quiet)
      else $error("bit test changed flags or file");

   property p_one_cycle;
      exec && !skip_taken && run && !sw_ctrl_wr |=> RETIRE && state_q == ST_EXEC;
   endproperty
   a_one_cycle: assert property (p_one_cycle)
      else $error("instruction took more than one cycle");

   property p_pin_source;
      exec && is_port && dec.op == OP_BSET |=>
         FILE_WDATA == ($past(port_val) | bit_mask($past(dec.bidx)));
   endproperty
   a_pin_source: assert property (p_pin_source)
      else $error("port operand not taken from pins");

   property p_prescaler;
      file_wr && dec.faddr == TMR0_ADDR |=> PRESCALER_CLR == $past(ctrl_q[CTRL_PSA]);
   endproperty
   a_prescaler: assert property (p_prescaler)
      else $error("timer write did not follow prescaler assignment");

endmodule
`default_nettype wire

/* File: bench/file_reg_alu_bit_ops_bench.sv */
// Self-checking bench for the file register ALU and bit operation executor
`timescale 1ns/1ps
`default_nettype none
module file_reg_alu_bit_ops_bench;
   import exec_pkg::*;

   // ****************************************
   // Signals and file space model
   // ****************************************
   logic CLK, ARST_N, FETCH_VALID, REG_WR, REG_RD;
   logic [13:0] FETCH_WORD;
   logic [7:0] PORTA_PINS, PORTB_PINS, REG_WDATA;
   logic [2:0] REG_ADDR;
   logic RETIRE, SKIP_FLUSH, FILE_WE, PRESCALER_CLR;
   logic [6:0] FILE_ADDR, FILE_WADDR;
   logic [7:0] FILE_WDATA, ACC, REG_RDATA;
   logic [2:0] FLAGS;
   logic [7:0] mem [0:127];
   wire logic [7:0] FILE_RDATA;
   int bad_count = 0;
   int samples_checked = 0;

   // Port addresses hold a latch value that differs from the pins
   assign FILE_RDATA = mem[FILE_ADDR];
   always @(posedge CLK) begin
      if (FILE_WE) begin
         mem[FILE_WADDR] <= FILE_WDATA;
      end
   end

   file_reg_alu_bit_ops i_file_reg_alu_bit_ops (.CLK(CLK), .ARST_N(ARST_N),
      .FETCH_WORD(FETCH_WORD), .FETCH_VALID(FETCH_VALID), .RETIRE(RETIRE),
      .SKIP_FLUSH(SKIP_FLUSH), .FILE_ADDR(FILE_ADDR), .FILE_RDATA(FILE_RDATA),
      .FILE_WE(FILE_WE), .FILE_WADDR(FILE_WADDR), .FILE_WDATA(FILE_WDATA),
      .PORTA_PINS(PORTA_PINS), .PORTB_PINS(PORTB_PINS), .PRESCALER_CLR(PRESCALER_CLR),
      .ACC(ACC), .FLAGS(FLAGS), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));

   initial begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end

   // ****************************************
   // Compare, report and bus tasks
   // ****************************************
   task automatic chk_val(input string what, input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_bit(input string what, input logic got, input logic exp);
      chk_val(what, {7'h00, got}, {7'h00, exp});
   endtask

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
      @(posedge CLK);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge CLK);
      REG_WR <= 1'b0;
   endtask

   task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
      @(posedge CLK);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge CLK);
      REG_RD <= 1'b0;
      #1;
      d = REG_RDATA;
   endtask

   // One word, then idle fetch; results checked in the cycle after execution
   task automatic run_op(input logic [13:0] w, input logic we, input logic [7:0] wd,
      input logic [7:0] acc, input logic [2:0] fl, input logic pclr);
      @(posedge CLK);
      FETCH_WORD <= w;
      FETCH_VALID <= 1'b1;
      @(posedge CLK);
      FETCH_VALID <= 1'b0;
      #1;
      chk_val("read addr", {1'b0, FILE_ADDR}, {1'b0, w[6:0]});
      @(posedge CLK);
      #1;
      chk_bit("retire", RETIRE, 1'b1);
      chk_bit("write strobe", FILE_WE, we);
      if (we) begin
         chk_val("write data", FILE_WDATA, wd);
         chk_val("write addr", {1'b0, FILE_WADDR}, {1'b0, w[6:0]});
      end
      chk_val("acc", ACC, acc);
      chk_val("flags", {5'h00, FLAGS}, {5'h00, fl});
      chk_bit("prescaler clear", PRESCALER_CLR, pclr);
      chk_bit("flush", SKIP_FLUSH, 1'b0);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic reset_values();
      logic [7:0] d;
      chk_val("acc at reset", ACC, 8'h00);
      reg_read(REG_CTRL, d);
      chk_val("ctrl reset", d, CTRL_RST);
      reg_write(REG_COUNT, 8'h55);
      reg_read(REG_COUNT, d);
      chk_val("count read only", d, 8'h00);
      reg_read(3'h5, d);
      chk_val("unmapped read", d, 8'h00);
   endtask

   task automatic byte_ops();
      mem[7'h04] = 8'hC2;
      mem[7'h20] = 8'h78;
      mem[7'h7F] = 8'hC2;
      mem[7'h30] = 8'hF0;
      reg_write(REG_ACC, 8'h17);
      run_op(14'h0704, 1'b0, 8'h00, 8'hD9, 3'h0, 1'b0);
      reg_write(REG_ACC, 8'h88);
      run_op(14'h07A0, 1'b1, 8'h00, 8'h88, 3'h7, 1'b0);
      reg_write(REG_ACC, 8'h17);
      reg_write(REG_FLAGS, 8'h03);
      run_op(14'h05FF, 1'b1, 8'h02, 8'h17, 3'h3, 1'b0);
      reg_write(REG_ACC, 8'h0F);
      run_op(14'h0530, 1'b0, 8'h00, 8'h00, 3'h7, 1'b0);
   endtask

   task automatic bit_ops();
      reg_write(REG_ACC, 8'h5A);
      reg_write(REG_FLAGS, 8'h05);
      for (int b = 0; b < 8; b++) begin
         mem[7'h40 + 7'(b)] = 8'hC7;
         mem[7'h48 + 7'(b)] = 8'h0A;
         run_op({4'h4, 3'(b), 7'h40 + 7'(b)}, 1'b1, 8'hC7 & ~(8'h01 << b),
            8'h5A, 3'h5, 1'b0);
         run_op({4'h5, 3'(b), 7'h48 + 7'(b)}, 1'b1, 8'h0A | (8'h01 << b),
            8'h5A, 3'h5, 1'b0);
      end
   endtask

   // Test word, then two adds back to back; the first add is dropped when taken
   task automatic skip_case(input logic bit_val);
      logic [7:0] c0, s0, c1, s1;
      mem[7'h50] = {6'h00, bit_val, 1'b0};
      mem[7'h51] = 8'h10;
      reg_write(REG_ACC, 8'h01);
      reg_write(REG_FLAGS, 8'h07);
      reg_read(REG_COUNT, c0);
      reg_read(REG_SKIPS, s0);
      @(posedge CLK);
      FETCH_WORD <= {4'h6, 3'h1, 7'h50};
      FETCH_VALID <= 1'b1;
      @(posedge CLK);
      FETCH_WORD <= 14'h0751;
      @(posedge CLK);
      #1;
      chk_bit("test retire", RETIRE, 1'b1);
      chk_bit("flush", SKIP_FLUSH, ~bit_val);
      chk_val("test flags", {5'h00, FLAGS}, 8'h07);
      @(posedge CLK);
      FETCH_VALID <= 1'b0;
      #1;
      chk_bit("dropped word", RETIRE, bit_val);
      chk_val("acc mid", ACC, bit_val ? 8'h11 : 8'h01);
      @(posedge CLK);
      #1;
      chk_bit("next retire", RETIRE, 1'b1);
      chk_val("acc end", ACC, bit_val ? 8'h21 : 8'h11);
      reg_read(REG_COUNT, c1);
      reg_read(REG_SKIPS, s1);
      chk_val("count", c1 - c0, bit_val ? 8'h03 : 8'h02);
      chk_val("skips", s1 - s0, {7'h00, ~bit_val});
   endtask

   task automatic port_and_timer();
      mem[PORTA_ADDR] = 8'hFF;
      mem[PORTB_ADDR] = 8'hFF;
      mem[TMR0_ADDR] = 8'h00;
      reg_write(REG_ACC, 8'h01);
      run_op({7'h0E, PORTA_ADDR}, 1'b0, 8'h00, 8'h3D, 3'h0, 1'b0);
      run_op({4'h5, 3'h0, PORTB_ADDR}, 1'b1, 8'h01, 8'h3D, 3'h0, 1'b0);
      reg_write(REG_CTRL, 8'h03);
      run_op({4'h5, 3'h0, TMR0_ADDR}, 1'b1, 8'h01, 8'h3D, 3'h0, 1'b1);
      run_op({7'h0F, TMR0_ADDR}, 1'b1, 8'h3E, 8'h3D, 3'h0, 1'b1);
      reg_write(REG_CTRL, 8'h01);
      run_op({4'h4, 3'h1, TMR0_ADDR}, 1'b1, 8'h3C, 8'h3D, 3'h0, 1'b0);
      // Words outside this block's set still retire but change nothing
      run_op(14'h3FFF, 1'b0, 8'h00, 8'h3D, 3'h0, 1'b0);
      run_op(14'h1C7F, 1'b0, 8'h00, 8'h3D, 3'h0, 1'b0);
   endtask

   // ****************************************
   // Main sequence and hang guard
   // ****************************************
   initial begin
      ARST_N = 1'b0;
      FETCH_WORD = 14'h0000;
      FETCH_VALID = 1'b0;
      PORTA_PINS = 8'h3C;
      PORTB_PINS = 8'h00;
      REG_ADDR = 3'h0;
      REG_WDATA = 8'h00;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      for (int i = 0; i < 128; i++) begin
         mem[i] = 8'h00;
      end
      repeat (2) @(posedge CLK);
      ARST_N <= 1'b1;
      reset_values();
      byte_ops();
      bit_ops();
      skip_case(1'b0);
      skip_case(1'b1);
      port_and_timer();
      wrap_up();
   end

   // Bounds the whole run; a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge CLK);
      bad_count++;
      $display("Error at %0t: run did not finish in time", $time);
      wrap_up();
   end
endmodule
`default_nettype wire
